// ### design/pmss_pkg.sv
/*
 * Package for the MAC-side status and strap block: interface modes,
 * strap sampling figures and reset timing.
 * Assumes a single 200 MHz system clock.
 */
package pmss_pkg;
    // Interface mode selected by the straps
    typedef enum logic [1:0] {
        PMSS_MODE_MII  = 2'b00,
        PMSS_MODE_RMII = 2'b01,
        PMSS_MODE_GPSI = 2'b10
    } pmss_mode_t;

    localparam int CLK_PERIOD_PS     = 5000;
    // Recommended hold of the pin reset after power on
    localparam int RESET_HOLD_MS     = 200;
    localparam longint RESET_HOLD_CYC =
        (longint'(RESET_HOLD_MS) * 64'd1_000_000_000) / CLK_PERIOD_PS;
    // Strap reset values: pull-downs make zero the default
    localparam logic RMII_STRAP_RST  = 1'b0;
    localparam logic GPSI_STRAP_RST  = 1'b0;
    localparam logic RPT_STRAP_RST   = 1'b0;
    // Depth of the pin synchroniser
    localparam int SYNC_STAGES       = 3;
endpackage : pmss_pkg

// ### design/pmss_sync.sv
/*
 * Three-flop synchroniser with agreement filter for pin inputs.
 * Assumes inputs are asynchronous to sys_clk.
 */
`timescale 1ns/1ps
module pmss_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             sys_clk, // System clock
    input  wire logic             rst,     // Sync reset, active high
    input  wire logic [WIDTH-1:0] pinIn,   // Raw pin levels
    output logic      [WIDTH-1:0] syncOut  // Filtered level
);
    import pmss_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] out;
    } pmss_sync_t;

    pmss_sync_t st;
    pmss_sync_t next_st;

    // First stage read only by second; change counts when s2 and s3 agree
    always_comb begin
        next_st    = st;
        next_st.s1 = pinIn;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        for (int i = 0; i < WIDTH; i++) begin
            if (st.s2[i] == st.s3[i]) begin
                next_st.out[i] = st.s3[i];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign syncOut = st.out;
endmodule : pmss_sync

// ### design/pmss_status.sv
/*
 * MAC-side status outputs of a 10/100 PHY: receive error, collision,
 * carrier sense and receive data valid, plus power-on strap capture.
 * Assumes medium events arrive as pins asynchronous to sys_clk and
 * that resetN is the device pin reset, held low for the whole reset.
 */
// How it works
// R1: MII: receive error rises on error, holds until data valid drops.
// R2: RMII: receive error holds until combined carrier/data valid drops.
// R3: GPSI: receive error output is unused, held low.
// R4: Straps sampled in reset; 00 MII, 01 GPSI, 1x RMII.
// R5: MII/GPSI: collision shown in half duplex, held low in full duplex.
// R6: Repeater strap 0: carrier follows rx, and tx in half duplex; 1: rx only.
// R7: MII/GPSI: carrier sense high while medium carries carrier.
// R8: Device in reset while reset pin low; host holds it 200 ms. The bench MAC model holds it for only HOLD + 1 = 17 cycles.
// R9: MII: data valid high while receive nibble is valid.
// R10: RMII: combined carrier/data valid high while medium not idle.
// R11: Captured straps stay fixed until the next reset.
`timescale 1ns/1ps
module pmss_status (
    input  wire logic             sys_clk,     // 200 MHz clock
    input  wire logic             rst,         // Sync reset, active high
    input  wire logic             resetN,      // Device reset pin, active low
    input  wire logic             rmiiStrap,   // RMII select strap pin
    input  wire logic             gpsiStrap,   // GPSI select strap pin
    input  wire logic             rptStrap,    // Repeater strap pin
    input  wire logic             fullDuplex,  // Link is full duplex
    input  wire logic             rxCarrier,   // Receive carrier present
    input  wire logic             rxNibValid,  // Receive nibble valid
    input  wire logic             txActive,    // Transmit in progress
    input  wire logic             collision,   // Collision on medium
    input  wire logic             rxErrDet,    // Receive error detected
    output logic                  rxDv,        // MII data valid
    output logic                  crsDv,       // RMII carrier/data valid
    output logic                  rxErr,       // Receive error
    output logic                  colOut,      // Collision
    output logic                  crsOut,      // Carrier sense
    output pmss_pkg::pmss_mode_t  mode,        // Latched interface mode
    output logic                  endpoint_mode, // Strap says endpoint
    output logic                  inReset      // Device held in reset
);
    import pmss_pkg::*;

    localparam int NIN = 10;

    logic [NIN-1:0] syncIn;

    // Every pin input passes the agreement synchroniser
    pmss_sync #(.WIDTH(NIN)) u_sync (
        .sys_clk (sys_clk),
        .rst     (rst),
        .pinIn   ({resetN, rmiiStrap, gpsiStrap, rptStrap, fullDuplex,
                   rxCarrier, rxNibValid, txActive, collision, rxErrDet}),
        .syncOut (syncIn)
    );

    logic sResetN;
    logic sRmii;
    logic sGpsi;
    logic sRpt;
    logic sFdx;
    logic sCar;
    logic sNib;
    logic sTx;
    logic sCol;
    logic sErr;
    assign {sResetN, sRmii, sGpsi, sRpt, sFdx, sCar, sNib, sTx, sCol, sErr} = syncIn;

    typedef struct packed {
        pmss_mode_t mode;
        logic       rpt;
        logic       held;
        logic       rxDv;
        logic       crsDv;
        logic       rxErr;
        logic       col;
        logic       crs;
    } pmss_state_t;

    pmss_state_t st;
    pmss_state_t next_st;

    always_comb begin
        next_st = st;
        next_st.held = ~sResetN;                      // see R8
        if (~sResetN) begin
            // Straps track the pins while in reset; last value is kept
            next_st.rpt = sRpt;                       // see R6
            if (sRmii) begin                          // see R4
                next_st.mode = PMSS_MODE_RMII;
            end else if (sGpsi) begin
                next_st.mode = PMSS_MODE_GPSI;
            end else begin
                next_st.mode = PMSS_MODE_MII;
            end
            next_st.rxDv  = 1'b0;
            next_st.crsDv = 1'b0;
            next_st.rxErr = 1'b0;
            next_st.col   = 1'b0;
            next_st.crs   = 1'b0;
        end else begin
            // Straps frozen outside reset, pins may become outputs
            next_st.mode = st.mode;                   // see R11
            next_st.rpt  = st.rpt;                    // see R11
            next_st.rxDv  = (st.mode == PMSS_MODE_MII) && sNib;    // see R9
            next_st.crsDv = (st.mode == PMSS_MODE_RMII) && sCar;   // see R10
            // Half duplex endpoint also senses own transmit
            next_st.crs = (st.mode != PMSS_MODE_RMII) &&
                          (sCar || (!sFdx && !st.rpt && sTx));     // see R6, see R7
            next_st.col = (st.mode != PMSS_MODE_RMII) && !sFdx && sCol; // see R5
            case (st.mode)
                PMSS_MODE_MII: begin
                    // Sticky until data valid falls; set wins
                    if (sErr && sNib) begin
                        next_st.rxErr = 1'b1;         // see R1
                    end else if (!sNib) begin
                        next_st.rxErr = 1'b0;         // see R1
                    end
                end
                PMSS_MODE_RMII: begin
                    if (sErr && sCar) begin
                        next_st.rxErr = 1'b1;         // see R2
                    end else if (!sCar) begin
                        next_st.rxErr = 1'b0;         // see R2
                    end
                end
                PMSS_MODE_GPSI: begin
                    next_st.rxErr = 1'b0;             // see R3
                end
                default: begin
                    next_st.rxErr = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st       <= '0;
            st.mode  <= PMSS_MODE_MII;
            st.rpt   <= RPT_STRAP_RST;
            st.held  <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign rxDv          = st.rxDv;
    assign crsDv         = st.crsDv;
    assign rxErr         = st.rxErr;
    assign colOut        = st.col;
    assign crsOut        = st.crs;
    assign mode          = st.mode;
    assign endpoint_mode = ~st.rpt;
    assign inReset       = st.held;
endmodule : pmss_status

// ### sim/pmss_status_asserts.sv
/* Port checker for pmss_status.
   Assumes one clock, sync rst and idle medium while in reset. */
`timescale 1ns/1ps
module pmss_status_asserts import pmss_pkg::*; (
    input wire logic sys_clk, rst, resetN, rmiiStrap, gpsiStrap, rptStrap,
    input wire logic fullDuplex, rxCarrier, rxNibValid, txActive, collision,
    input wire logic rxErrDet, rxDv, crsDv, rxErr, colOut, crsOut, endpoint_mode,
    input wire logic inReset,
    input wire pmss_mode_t mode
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // All status outputs quiet
    wire quiet = !rxDv && !crsDv && !rxErr && !colOut && !crsOut;
    a_gpsi_err_low: assert property (mode == PMSS_MODE_GPSI |-> !rxErr)
        else $error("rxErr high in GPSI");
    a_mii_err_hold: assert property
        (mode == PMSS_MODE_MII && $past(rxErr) && rxDv |-> rxErr)
        else $error("rxErr dropped while rxDv high");
    a_mii_err_dv: assert property (mode == PMSS_MODE_MII && rxErr |-> rxDv)
        else $error("rxErr high without rxDv");
    a_rmii_err_hold: assert property
        (mode == PMSS_MODE_RMII && $past(rxErr) && crsDv |-> rxErr)
        else $error("rxErr dropped while crsDv high");
    a_rmii_no_col: assert property (mode == PMSS_MODE_RMII |-> !colOut && !crsOut)
        else $error("col or crs active in RMII");
    a_crsdv_rmii_only: assert property (mode != PMSS_MODE_RMII |-> !crsDv)
        else $error("crsDv outside RMII");
    a_fdx_col_low: assert property (fullDuplex [*8] |-> !colOut)
        else $error("colOut high in full duplex");
    a_reset_quiet: assert property (inReset && $past(inReset) |-> quiet)
        else $error("output active in reset");
    a_reset_follow: assert property (!resetN [*8] |-> inReset)
        else $error("inReset low while pin low");
    a_strap_rmii: assert property
        ((inReset && rmiiStrap) [*8] |-> mode == PMSS_MODE_RMII)
        else $error("RMII strap not taken");
    a_mode_hold: assert property (!inReset && !$past(inReset) |-> $stable(mode))
        else $error("mode changed out of reset");
    c_err: cover property (rxErr && rxDv);
    c_col: cover property (colOut);
    c_rmii: cover property (crsDv && rxErr);
endmodule : pmss_status_asserts

bind pmss_status pmss_status_asserts chk_i (.*);

// ### sim/pmss_mac_model.sv
/* MAC-side partner: owns the device reset pin.
   Assumes go is a one-cycle request from the bench. */
`timescale 1ns/1ps
module pmss_mac_model #(parameter int HOLD = 16) (
    input  wire logic sys_clk,       // System clock
    input  wire logic go,            // Start a device reset
    output logic      resetN = 1'b0  // Device reset pin, active low
);
    int cnt = 0;
    // Hold is scaled down; the real host waits far longer
    always @(posedge sys_clk) begin
        if (go) cnt <= HOLD;
        else if (cnt > 0) cnt <= cnt - 1;
        resetN <= #1 (cnt == 0 && !go);
    end
endmodule : pmss_mac_model

// ### sim/testbench.sv
/* Directed bench for pmss_status.
   Assumes outputs settle within 8 cycles of a pin change. */
`timescale 1ns/1ps
module testbench;
    import pmss_pkg::*;
    logic sys_clk = 0, rst = 1, go = 0, rmiiStrap = 0, gpsiStrap = 0, rptStrap = 0;
    logic fullDuplex = 0, rxCarrier = 0, rxNibValid = 0, txActive = 0;
    logic collision = 0, rxErrDet = 0;
    logic resetN, rxDv, crsDv, rxErr, colOut, crsOut, endpoint_mode, inReset;
    pmss_mode_t mode;
    int bad_count = 0, n_tests = 0;
    always #2.5 sys_clk = ~sys_clk;
    pmss_status uut (.*);
    pmss_mac_model mac (.sys_clk(sys_clk), .go(go), .resetN(resetN));
    // Drive always 1 ns after the edge
    task automatic cyc(int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : cyc
    task automatic chk(string nm, logic [1:0] seen, logic [1:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : chk
    task automatic results;
        $display("Checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : results
    // Reset the device with new straps, then scramble the pins
    task automatic boot(logic r, logic g, logic p);
        {fullDuplex, rxCarrier, rxNibValid, txActive, collision, rxErrDet} = '0;
        go = 1;
        cyc(1);
        go = 0;
        {rmiiStrap, gpsiStrap, rptStrap} = {r, g, p};
        cyc(8);
        chk("inReset", inReset, 1);
        for (int i = 0; !(i > 8 && !inReset); i++) begin
            if (i > 99) begin bad_count++; results; end
            cyc(1);
        end
        {rmiiStrap, gpsiStrap, rptStrap} = ~{r, g, p};
        cyc(8);
        chk("mode", mode, r ? PMSS_MODE_RMII : g ? PMSS_MODE_GPSI : PMSS_MODE_MII);
        chk("endpoint", endpoint_mode, !p);
    endtask : boot
    task automatic t_mii;
        boot(0, 0, 0);
        {rxNibValid, rxErrDet} = 2'b11;
        cyc(3);
        rxErrDet = 0;
        cyc(8);
        chk("rxDv", rxDv, 1);
        chk("rxErr", rxErr, 1);
        {rxNibValid, txActive, collision} = 3'b011;
        cyc(8);
        chk("rxErr", rxErr, 0);
        chk("crs", crsOut, 1);
        chk("col", colOut, 1);
        fullDuplex = 1;
        cyc(8);
        chk("col", colOut, 0);
        $display("mii test done");
    endtask : t_mii
    task automatic t_rmii;
        boot(1, 1, 1);
        {rxCarrier, rxErrDet, collision} = 3'b111;
        cyc(3);
        rxErrDet = 0;
        cyc(8);
        chk("crsDv", crsDv, 1);
        chk("rxErr", rxErr, 1);
        chk("col", colOut, 0);
        rxCarrier = 0;
        cyc(8);
        chk("rxErr", rxErr, 0);
        $display("rmii test done");
    endtask : t_rmii
    task automatic t_gpsi;
        boot(0, 1, 1);
        {rxCarrier, rxNibValid, rxErrDet, collision} = 4'hf;
        cyc(10);
        chk("rxErr", rxErr, 0);
        chk("crs", crsOut, 1);
        chk("col", colOut, 1);
        {rxCarrier, rxNibValid, txActive} = 3'b001;
        cyc(8);
        chk("crs", crsOut, 0);
        $display("gpsi test done");
    endtask : t_gpsi
    initial begin
        cyc(20);
        rst = 0;
        t_mii;
        t_rmii;
        t_gpsi;
        boot(1, 0, 0);
        // Mid-run power-on reset returns the reset values
        rst = 1;
        cyc(2);
        chk("rstMode", mode, PMSS_MODE_MII);
        chk("rstEndpoint", endpoint_mode, 1);
        chk("rstInReset", inReset, 1);
        chk("rstErr", rxErr, 0);
        rst = 0;
        cyc(2);
        $display("reset test done");
        results;
    end
endmodule : testbench
